//--- src/fcg_pkg.sv
// flash command gate package: register map, fields, codes, states
// assumes a 32-bit apb slave with word-aligned registers
package fcg_pkg;

  // register byte offsets
  localparam logic [7:0] FCG_STAT_OFS   = 8'h00;
  localparam logic [7:0] FCG_PARAM0_OFS = 8'h04;
  localparam logic [7:0] FCG_PARAM1_OFS = 8'h08;
  localparam logic [7:0] FCG_CFG_OFS    = 8'h0C;

  // status bit positions
  localparam int FCG_CMD_COMPLETE_FLAG_BIT   = 7;
  localparam int FCG_RDCOL_BIT  = 6;
  localparam int FCG_ACC_BIT    = 5;
  localparam int FCG_PVIOL_BIT  = 4;
  localparam int FCG_VFAIL_BIT  = 0;

  // config bit positions
  localparam int FCG_SPECIAL_BIT = 0;
  localparam int FCG_SECURE_BIT  = 1;
  localparam int FCG_MASS_ERASE_ENABLE_FIELD_LSB    = 2;

  localparam logic [1:0] FCG_MASS_ERASE_ENABLE_FIELD_DISABLE = 2'h2;

  // command codes
  localparam logic [7:0] FCG_CMD_READ_ONES_SECTION_CMD = 8'h01;
  localparam logic [7:0] FCG_CMD_PGMCHK = 8'h02;
  localparam logic [7:0] FCG_CMD_RDRSRC = 8'h03;
  localparam logic [7:0] FCG_CMD_PGM4   = 8'h06;
  localparam logic [7:0] FCG_CMD_ERSSCR = 8'h09;
  localparam logic [7:0] FCG_CMD_RD1ALL = 8'h40;
  localparam logic [7:0] FCG_CMD_RDONCE = 8'h41;
  localparam logic [7:0] FCG_CMD_PGMONC = 8'h43;
  localparam logic [7:0] FCG_CMD_ERSALL = 8'h44;
  localparam logic [7:0] FCG_CMD_VFYKEY = 8'h45;
  localparam logic [7:0] FCG_CMD_ERSALU = 8'h49;

  // margin choices
  localparam logic [7:0] FCG_MRG_NORMAL  = 8'h00;
  localparam logic [7:0] FCG_MRG_USER    = 8'h01;
  localparam logic [7:0] FCG_MRG_FACTORY = 8'h02;

  // reset values
  localparam logic [31:0] FCG_CFG_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    FCG_IDLE  = 2'b00,
    FCG_CHECK = 2'b01,
    FCG_READ  = 2'b10,
    FCG_DONE  = 2'b11
  } fcg_state_e;

  typedef struct packed {
    logic [23:0] addr;
    logic [23:0] last;
    logic        req;
  } fcg_rd_s;

endpackage

//--- src/fcg_perm.sv
// flash command gate: mode and security permission decode
// assumes a pure combinational use from the command gate top
`timescale 1ns/1ps
module fcg_perm
  import fcg_pkg::*;
(
  input  wire logic [7:0] cmd_code,
  input  wire logic       special,
  input  wire logic       secure,
  input  wire logic [1:0] mass_erase_enable_field,
  output logic            known,
  output logic            allowed
);

  wire known_w = (cmd_code == FCG_CMD_READ_ONES_SECTION_CMD) || (cmd_code == FCG_CMD_PGMCHK)
              || (cmd_code == FCG_CMD_RDRSRC) || (cmd_code == FCG_CMD_PGM4)
              || (cmd_code == FCG_CMD_ERSSCR) || (cmd_code == FCG_CMD_RD1ALL)
              || (cmd_code == FCG_CMD_RDONCE) || (cmd_code == FCG_CMD_PGMONC)
              || (cmd_code == FCG_CMD_ERSALL) || (cmd_code == FCG_CMD_VFYKEY)
              || (cmd_code == FCG_CMD_ERSALU);
  wire sec_ok  = (cmd_code == FCG_CMD_RD1ALL) || (cmd_code == FCG_CMD_ERSALL)
              || (cmd_code == FCG_CMD_ERSALU);
  wire mass_erase_enable_field_off = (mass_erase_enable_field == FCG_MASS_ERASE_ENABLE_FIELD_DISABLE);

  assign known = known_w;
  assign allowed = known_w && (!special
                   || (!mass_erase_enable_field_off && (!secure || sec_ok)));

endmodule

//--- src/fcg_top.sv
// flash command gate top: apb registers, command checks, read-ones section
// assumes a flash array read port answering one cycle after a request
// Contract
// - normal mode accepts every defined code in all security states
// - special mode: unsecure all, secure only 40/44/49, mass_erase_enable_field off none
// - disallowed command sets access error and does not execute
// - read-ones section takes a margin choice for its reads
// - margin applied only during the command; else normal level
// - unrecognised code sets access error and aborts
// - bad parameter byte sets access error and aborts
// - read during command may return bad data, sets collision flag
// - param layout: code, address 3 bytes, count 2 bytes, margin
// - unaligned start address sets access error
// - invalid flash address sets access error
// - margin 00 normal, 01 user, 02 factory
// - undefined margin code sets access error
// - section crossing block boundary sets access error
// - zero longword count sets access error
// - read every longword at margin, verify fail if not all ones
// - complete flag sets at finish, pass or fail
// - writing 1 to complete flag launches; stays 0 until done; no launch here while access error or violation flag is set
// - parameter writes ignored while complete flag is 0
// - failed checks skip execution and set complete flag
// - verify failure only evaluated after all errors pass
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module fcg_top
  import fcg_pkg::*;
#(
  parameter int ADDR_W  = 24,
  parameter int FLASH_B = 32768,
  parameter int BLOCK_B = 32768
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [23:0] flash_addr,
  output logic             flash_req,
  output logic       [1:0] flash_margin,
  input  wire logic [31:0] flash_rdata,
  input  wire logic        cpu_read
);

  initial begin
    if (ADDR_W != 24 || BLOCK_B > FLASH_B || BLOCK_B < 4)
      $error("fcg_top: unsupported geometry");
  end

  localparam logic [24:0] FLASH_END = 25'(FLASH_B);
  localparam logic [24:0] BLOCK_MSK = 25'(BLOCK_B - 1);

  fcg_state_e  st_q, st_d;
  logic        cmd_complete_flag_q, acc_q, pviol_q, rdcol_q, vfail_q;
  logic [63:0] param_q;
  logic [31:0] cfg_q;
  logic [23:0] addr_q, last_q;
  logic  [1:0] margin_q;
  logic        pend_q;
  logic        iss_done_q;
  fcg_rd_s     rd;

  // apb decode
  wire wr_en    = psel && penable && pwrite;
  wire hit_stat = (paddr == FCG_STAT_OFS);
  wire hit_p0   = (paddr == FCG_PARAM0_OFS);
  wire hit_p1   = (paddr == FCG_PARAM1_OFS);
  wire hit_cfg  = (paddr == FCG_CFG_OFS);
  wire hit_any  = hit_stat || hit_p0 || hit_p1 || hit_cfg;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  wire [31:0] stat_w = {24'h000000, cmd_complete_flag_q, rdcol_q, acc_q, pviol_q,
                        3'h0, vfail_q};
  assign prdata = hit_stat ? stat_w
                : hit_p0   ? param_q[63:32]
                : hit_p1   ? param_q[31:0]
                : hit_cfg  ? cfg_q
                : 32'h0000_0000;

  wire [7:0]  cmd_code = param_q[63:56];
  wire [23:0] start_a  = param_q[55:32];
  wire [15:0] lw_cnt   = param_q[31:16];
  wire [7:0]  mrg_byte = param_q[15:8];

  wire special = cfg_q[FCG_SPECIAL_BIT];
  wire secure  = cfg_q[FCG_SECURE_BIT];
  wire [1:0] mass_erase_enable_field = cfg_q[FCG_MASS_ERASE_ENABLE_FIELD_LSB +: 2];

  logic known, allowed;
  fcg_perm i_fcg_perm (
    .cmd_code (cmd_code),
    .special  (special),
    .secure   (secure),
    .mass_erase_enable_field     (mass_erase_enable_field),
    .known    (known),
    .allowed  (allowed)
  );

  wire w1_cmd_complete_flag = wr_en && hit_stat && pwdata[FCG_CMD_COMPLETE_FLAG_BIT];
  wire launch  = w1_cmd_complete_flag && cmd_complete_flag_q && !acc_q && !pviol_q;

  // section end = start + 4*count - 4
  wire [24:0] sec_len = {7'h00, lw_cnt, 2'b00};
  wire [24:0] sec_end = {1'b0, start_a} + sec_len - 25'h0000004;
  wire [24:0] blk_s   = {1'b0, start_a} & ~BLOCK_MSK;
  wire [24:0] blk_e   = sec_end & ~BLOCK_MSK;

  wire bad_align = (start_a[1:0] != 2'b00);
  wire bad_addr  = ({1'b0, start_a} >= FLASH_END);
  wire bad_mrg   = (mrg_byte > FCG_MRG_FACTORY);
  wire bad_cnt   = (lw_cnt == 16'h0000);
  wire bad_blk   = !bad_cnt && (blk_s != blk_e);

  wire is_read_ones_section_cmd = (cmd_code == FCG_CMD_READ_ONES_SECTION_CMD);
  wire param_err = is_read_ones_section_cmd &&
                   (bad_align || bad_addr || bad_mrg || bad_cnt || bad_blk);
  wire chk_err = !known || !allowed || param_err;

  always_comb begin
    st_d = st_q;
    case (st_q)
      FCG_IDLE:  if (launch) st_d = FCG_CHECK;
      FCG_CHECK: st_d = (chk_err || !is_read_ones_section_cmd) ? FCG_DONE : FCG_READ;
      // last data word is checked in the cycle after the last request
      FCG_READ:  if (iss_done_q) st_d = FCG_DONE;
      FCG_DONE:  st_d = FCG_IDLE;
      default:   st_d = FCG_IDLE;
    endcase
  end

  assign rd.req  = (st_q == FCG_READ) && !iss_done_q;
  assign rd.addr = addr_q;
  assign rd.last = last_q;
  assign flash_req  = rd.req;
  assign flash_addr = rd.addr;
  assign flash_margin = rd.req ? margin_q : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= FCG_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_q <= 64'h0000_0000_0000_0000;
      cfg_q   <= FCG_CFG_RST;
    end else begin
      if (wr_en && hit_p0 && cmd_complete_flag_q)
        param_q[63:32] <= pwdata;
      if (wr_en && hit_p1 && cmd_complete_flag_q)
        param_q[31:0] <= pwdata;
      if (wr_en && hit_cfg)
        cfg_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q   <= 24'h000000;
      last_q   <= 24'h000000;
      margin_q <= 2'b00;
      pend_q   <= 1'b0;
      iss_done_q <= 1'b0;
    end else begin
      if (st_q == FCG_CHECK) begin
        addr_q   <= start_a;
        last_q   <= sec_end[23:0];
        margin_q <= mrg_byte[1:0];
        pend_q   <= 1'b0;
        iss_done_q <= 1'b0;
      end else if (st_q == FCG_READ) begin
        pend_q <= rd.req;
        if (rd.req) begin
          if (addr_q == last_q)
            iss_done_q <= 1'b1;
          else
            addr_q <= addr_q + 24'h000004;
        end
      end else begin
        pend_q <= 1'b0;
      end
    end
  end

  // data of request at addr_q arrives while pend_q
  wire rd_fail = (st_q == FCG_READ) && pend_q &&
                 (flash_rdata != 32'hFFFF_FFFF);

  // status flags; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_complete_flag_q  <= 1'b1;
      acc_q   <= 1'b0;
      pviol_q <= 1'b0;
      rdcol_q <= 1'b0;
      vfail_q <= 1'b0;
    end else begin
      if (st_q == FCG_DONE)
        cmd_complete_flag_q <= 1'b1;
      else if (launch)
        cmd_complete_flag_q <= 1'b0;
      if (st_q == FCG_CHECK && chk_err)
        acc_q <= 1'b1;
      else if (wr_en && hit_stat && pwdata[FCG_ACC_BIT])
        acc_q <= 1'b0;
      if (wr_en && hit_stat && pwdata[FCG_PVIOL_BIT])
        pviol_q <= 1'b0;
      if (cpu_read && !cmd_complete_flag_q)
        rdcol_q <= 1'b1;
      else if (wr_en && hit_stat && pwdata[FCG_RDCOL_BIT])
        rdcol_q <= 1'b0;
      if (rd_fail)
        vfail_q <= 1'b1;
      else if (launch)
        vfail_q <= 1'b0;
    end
  end

endmodule

//--- sim/fcg_asserts.sv
// checker: flash gate port assertions
// assumes a bind onto fcg_top
`timescale 1ns/1ps
module fcg_asserts
  import fcg_pkg::*;
#(
  parameter int FLASH_B = 32768,
  parameter int BLOCK_B = 32768
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic [23:0] flash_addr,
  input wire logic        flash_req,
  input wire logic [1:0]  flash_margin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire st_rd = psel && !pwrite && paddr == FCG_STAT_OFS;
  a_margin_idle: assert property
    (!flash_req |-> flash_margin == 2'h0) else $error("margin when idle");
  a_margin_legal: assert property
    (flash_margin != 2'h3) else $error("margin code");
  a_req_align: assert property
    (flash_req |-> flash_addr[1:0] == 2'h0) else $error("unaligned read");
  a_req_range: assert property
    (flash_req |-> flash_addr < FLASH_B) else $error("read out of range");
  a_req_step: assert property
    (flash_req && $past(flash_req) |-> flash_addr == $past(flash_addr) + 24'h4)
    else $error("read step");
  a_margin_hold: assert property
    (flash_req && $past(flash_req) |-> $stable(flash_margin))
    else $error("margin moved");
  a_block_keep: assert property
    (flash_req && $past(flash_req) |-> flash_addr % BLOCK_B != 0)
    else $error("block crossed");
  a_busy_flag: assert property
    (st_rd && flash_req |-> !prdata[FCG_CMD_COMPLETE_FLAG_BIT]) else $error("cmd_complete_flag in run");
  cover property (flash_req && flash_margin == 2'h2);
  cover property ($fell(flash_req));
  cover property (st_rd && !prdata[FCG_CMD_COMPLETE_FLAG_BIT]);
endmodule

bind fcg_top fcg_asserts #(.FLASH_B(FLASH_B), .BLOCK_B(BLOCK_B)) i_fcg_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .flash_addr(flash_addr),
  .flash_req(flash_req), .flash_margin(flash_margin));

//--- sim/fcg_top_tb.sv
// bench: flash command gate over apb
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
module fcg_top_tb;
  import fcg_pkg::*;
  localparam int FB = 256;
  localparam int BB = 128;
  localparam logic [7:0] CS [13] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h09,
    8'h40, 8'h41, 8'h43, 8'h44, 8'h45, 8'h49, 8'h00, 8'hFF};
  localparam logic [3:0] FS [6] = '{4'h0, 4'h2, 4'h8, 4'h1, 4'h3, 4'h9};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        cpu_read = 0, pready, pslverr, flash_req, slv;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 0, flash_rdata = 0, prdata, rd;
  logic [23:0] flash_addr, bad_a = 24'hFFFFFF;
  logic [1:0]  flash_margin, m_seen;
  int          err_total = 0, n_checks = 0, cyc = 0, n_req = 0;
  fcg_top #(.FLASH_B(FB), .BLOCK_B(BB)) i_fcg_top (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(flash_addr), .flash_req(flash_req),
    .flash_margin(flash_margin), .flash_rdata(flash_rdata),
    .cpu_read(cpu_read));
  always #2 pclk = ~pclk;
  // array model: one word of the section reads with a zero bit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    flash_rdata <= flash_req && flash_addr != bad_a ? '1 : 32'hFFFF7FFF;
    if (flash_req) begin
      n_req <= n_req + 1;
      m_seen <= flash_margin;
    end
    if (cyc == 10000) begin
      err_total++;
      give_verdict;
    end
  end
  task give_verdict;
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp, input string s);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wait_done;
    int i;
    i = 0;
    do begin
      apb(0, FCG_STAT_OFS, 0);
      i++;
    end while (rd[FCG_CMD_COMPLETE_FLAG_BIT] !== 1'b1 && i < 100);
  endtask
  task run(input logic [7:0] c, input logic [3:0] f, input logic [23:0] a,
           input logic [15:0] n, input logic [7:0] m);
    logic acc, vf, sec;
    sec = c == FCG_CMD_READ_ONES_SECTION_CMD;
    acc = !(c inside {FCG_CMD_READ_ONES_SECTION_CMD, FCG_CMD_PGMCHK, FCG_CMD_RDRSRC,
      FCG_CMD_PGM4, FCG_CMD_ERSSCR, FCG_CMD_RD1ALL, FCG_CMD_RDONCE,
      FCG_CMD_PGMONC, FCG_CMD_ERSALL, FCG_CMD_VFYKEY, FCG_CMD_ERSALU});
    if (f[0]) acc |= f[3:2] == FCG_MASS_ERASE_ENABLE_FIELD_DISABLE || (f[1] && !(c inside
      {FCG_CMD_RD1ALL, FCG_CMD_ERSALL, FCG_CMD_ERSALU}));
    if (sec) acc |= a[1:0] != 0 || a >= FB || m > 2 || n == 0 ||
      a / BB != (a + 4 * n - 1) / BB;
    vf = !acc && sec && bad_a >= a && bad_a < a + 4 * n;
    apb(1, FCG_CFG_OFS, {28'h0, f});
    apb(1, FCG_PARAM0_OFS, {c, a});
    apb(1, FCG_PARAM1_OFS, {n, m, 8'h00});
    n_req = 0;
    apb(1, FCG_STAT_OFS, 32'h80);
    wait_done;
    chk(rd & 32'hF1, 32'h80 | {acc, 5'h0} | vf, "status");
    chk(n_req, !acc && sec ? n : 0, "reads");
    if (!acc && sec) chk(m_seen, m, "margin");
    apb(1, FCG_STAT_OFS, 32'h70);
  endtask
  task t_regs;
    apb(0, FCG_STAT_OFS, 0);
    chk(rd, 32'h80, "status reset");
    apb(0, FCG_CFG_OFS, 0);
    chk(rd, FCG_CFG_RST, "cfg reset");
    apb(1, 8'h40, '1);
    chk(slv, 1, "unmapped");
  endtask
  task t_params;
    run(8'h01, 0, 24'h2, 1, 0);
    run(8'h01, 0, 24'(FB), 1, 0);
    run(8'h01, 0, 0, 1, 3);
    run(8'h01, 0, 0, 0, 0);
    run(8'h01, 0, 24'(BB - 4), 2, 0);
    run(8'h01, 0, 24'(BB - 8), 2, 1);
    run(8'h01, 0, 24'(FB - 4), 1, 2);
    bad_a = 24'h8;
    for (int m = 0; m < 4; m++) run(8'h01, 0, 4, 3, 8'(m));
    bad_a = 24'hFFFFFF;
  endtask
  task t_lock;
    apb(1, FCG_PARAM0_OFS, 32'hFF000000);
    apb(1, FCG_STAT_OFS, 32'h80);
    wait_done;
    apb(1, FCG_PARAM0_OFS, 32'h01000000);
    apb(1, FCG_PARAM1_OFS, 32'h00100000);
    n_req = 0;
    apb(1, FCG_STAT_OFS, 32'h80);
    apb(0, FCG_STAT_OFS, 0);
    chk(rd & 32'hF1, 32'hA0, "refused");
    chk(n_req, 0, "refused reads");
    apb(1, FCG_STAT_OFS, 32'h70);
    apb(1, FCG_STAT_OFS, 32'h80);
    cpu_read <= 1;
    apb(0, FCG_STAT_OFS, 0);
    chk(rd[7], 0, "busy");
    apb(1, FCG_PARAM0_OFS, 32'h09000000);
    cpu_read <= 0;
    wait_done;
    chk(rd & 32'hF1, 32'hC0, "collision");
    chk(n_req, 16, "count");
    apb(0, FCG_PARAM0_OFS, 0);
    chk(rd, 32'h01000000, "locked");
    apb(1, FCG_STAT_OFS, 32'h70);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    foreach (CS[i]) foreach (FS[j]) run(CS[i], FS[j], 0, 1, 0);
    t_params;
    t_lock;
    give_verdict;
  end
endmodule
